// ==== shared/t2r_pkg.sv ====
/*
  Constants, register map and mode codes for the reload/clock-out/baud
  timer. Assumes an 8-bit register port with a 3-bit word index.
*/
package t2r_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int COUNT_W = 16;

  // Register indices on the plain register port
  localparam logic [ADDR_W-1:0] REG_CONTROL = 3'h0;
  localparam logic [ADDR_W-1:0] REG_MODE = 3'h1;
  localparam logic [ADDR_W-1:0] REG_COUNT_LO = 3'h2;
  localparam logic [ADDR_W-1:0] REG_COUNT_HI = 3'h3;
  localparam logic [ADDR_W-1:0] REG_RELOAD_LO = 3'h4;
  localparam logic [ADDR_W-1:0] REG_RELOAD_HI = 3'h5;

  // Control register fields
  localparam int CTL_OVF = 7;
  localparam int CTL_EXT = 6;
  localparam int CTL_RX_BAUD = 5;
  localparam int CTL_TX_BAUD = 4;
  localparam int CTL_EXT_EN = 3;
  localparam int CTL_RUN = 2;
  localparam int CTL_COUNTER = 1;
  localparam int CTL_CAPTURE = 0;

  // Mode register fields
  localparam int MOD_CLK_OUT = 1;
  localparam int MOD_DOWN_EN = 0;

  localparam logic [DATA_W-1:0] CONTROL_RST = 8'h00;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
  localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hFFFF;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;

  // Oscillator clocks per machine cycle
  localparam logic [3:0] MC_CLKS_6 = 4'h6;
  localparam logic [3:0] MC_CLKS_12 = 4'hC;
  localparam logic [3:0] PRE_ZERO = 4'h0;
  localparam logic [3:0] PRE_ONE = 4'h1;

  typedef enum logic [4:0] {
    MODE_OFF = 5'b00001,
    MODE_RELOAD = 5'b00010,
    MODE_CAPTURE = 5'b00100,
    MODE_CLKOUT = 5'b01000,
    MODE_BAUD = 5'b10000
  } t2r_mode_type;

endpackage

// ==== hdl/t2r_pin_sampler.sv ====
/*
  Pin synchroniser and sampled falling-edge detector.
  Assumes sample_tick_in is a one-cycle pulse from the same clock.
*/
`timescale 1ns/10ps
module t2r_pin_sampler
  import t2r_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic pin_in,
  input wire logic sample_tick_in,
  output logic level_out,
  output logic fall_out
);

  logic sync_a;
  logic sync_b;
  logic samp;
  logic samp_d;

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
    end
    else if (ce_in)
    begin
      sync_a <= pin_in;
      sync_b <= sync_a;
    end
  end

  // Sampled once per tick: an edge needs high then low on two ticks
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      samp <= 1'b1;
      samp_d <= 1'b1;
    end
    else if (ce_in && sample_tick_in)
    begin
      samp <= sync_b;
      samp_d <= samp;
    end
  end

  assign level_out = samp;
  assign fall_out = sample_tick_in & samp_d & ~samp;

endmodule

// ==== hdl/t2r_timer.sv ====
/*
  Sixteen-bit reload timer with up/down count, clock-out and baud
  generation. Assumes the register master obeys one-cycle strobes and
  that the other timer's overflow pulse is on the same clock.
*/
// The register addresses and strobed register access were decided locally.
`timescale 1ns/10ps
module t2r_timer
  import t2r_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic clk12_mode_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  input wire logic timer_clock_pin_in,
  output logic timer_clock_pin_out,
  output logic timer_clock_pin_oe_out,
  input wire logic trigger_direction_input_in,
  input wire logic other_timer_overflow_in,
  input wire logic timer_irq_enable_in,
  output logic timer_irq_out,
  output logic tx_baud_tick_out,
  output logic rx_baud_tick_out
);

  logic overflow_flag;
  logic external_edge_flag;
  logic rx_baud_select;
  logic tx_baud_select;
  logic external_trigger_enable;
  logic run_control;
  logic counter_select;
  logic capture_reload_select;
  logic clock_out_enable;
  logic down_count_enable;
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] next_count;
  logic [DATA_W-1:0] reload_high_byte;
  logic [DATA_W-1:0] reload_low_byte;
  logic [COUNT_W-1:0] reload_value;
  logic clock_out_level;
  logic [3:0] prescale;
  logic [3:0] mc_last;
  logic machine_tick;
  logic fast_tick;
  logic pin_tick;
  logic count_tick;
  logic clk_fall;
  logic trig_level;
  logic trig_fall;
  logic ctl_wr;
  logic mode_wr;
  logic cnt_lo_wr;
  logic cnt_hi_wr;
  logic cnt_wr;
  logic set_ovf;
  logic set_ext;
  logic tog_ext;
  logic roll_baud;
  logic roll_clk;
  logic next_ovf;
  logic next_ext;
  t2r_mode_type mode;

  assign ctl_wr = reg_wr_in && (reg_addr_in == REG_CONTROL);
  assign mode_wr = reg_wr_in && (reg_addr_in == REG_MODE);
  assign cnt_lo_wr = reg_wr_in && (reg_addr_in == REG_COUNT_LO);
  assign cnt_hi_wr = reg_wr_in && (reg_addr_in == REG_COUNT_HI);
  assign cnt_wr = cnt_lo_wr || cnt_hi_wr;
  assign reload_value = {reload_high_byte, reload_low_byte};

  // Machine cycle prescaler; 12-clock setting is a static strap
  assign mc_last = (clk12_mode_in ? MC_CLKS_12 : MC_CLKS_6) - PRE_ONE;

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      prescale <= PRE_ZERO;
    else if (ce_in)
      prescale <= (prescale == mc_last) ? PRE_ZERO : prescale + PRE_ONE;
  end

  assign machine_tick = (prescale == mc_last);
  // Osc rate in 6-clock mode, half of it in 12-clock mode
  assign fast_tick = !clk12_mode_in || prescale[0];
  // Count pin sampled every six clocks caps the external count rate
  assign pin_tick = (prescale == (MC_CLKS_6 - PRE_ONE)) ||
                    (prescale == (MC_CLKS_12 - PRE_ONE));

  t2r_pin_sampler u_clk_pin (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .pin_in(timer_clock_pin_in),
    .sample_tick_in(pin_tick),
    .level_out(),
    .fall_out(clk_fall)
  );

  t2r_pin_sampler u_trig_pin (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .pin_in(trigger_direction_input_in),
    .sample_tick_in(machine_tick),
    .level_out(trig_level),
    .fall_out(trig_fall)
  );

  always_comb
  begin
    if (!run_control)
      mode = MODE_OFF;
    else if (rx_baud_select || tx_baud_select)
      mode = MODE_BAUD;
    else if (capture_reload_select)
      mode = MODE_CAPTURE;
    else if (clock_out_enable)
      mode = MODE_CLKOUT;
    else
      mode = MODE_RELOAD;
  end

  always_comb
  begin
    if (counter_select)
      count_tick = clk_fall;
    else if (mode == MODE_BAUD || mode == MODE_CLKOUT)
      count_tick = fast_tick;
    else
      count_tick = machine_tick;
  end

  always_comb
  begin
    next_count = count;
    set_ovf = 1'b0;
    set_ext = 1'b0;
    tog_ext = 1'b0;
    roll_baud = 1'b0;
    roll_clk = 1'b0;
    unique case (mode)
      MODE_OFF:
      begin
        next_count = count;
      end
      MODE_BAUD:
      begin
        if (count_tick)
        begin
          if (count == COUNT_MAX)
          begin
            next_count = reload_value;
            roll_baud = 1'b1;
          end
          else
            next_count = count + COUNT_ONE;
        end
        if (external_trigger_enable && trig_fall)
          set_ext = 1'b1;
      end
      MODE_CLKOUT:
      begin
        if (count_tick)
        begin
          if (count == COUNT_MAX)
          begin
            next_count = reload_value;
            roll_clk = 1'b1;
          end
          else
            next_count = count + COUNT_ONE;
        end
        if (external_trigger_enable && trig_fall)
        begin
          next_count = reload_value;
          set_ext = 1'b1;
        end
      end
      MODE_CAPTURE:
      begin
        if (count_tick)
        begin
          next_count = count + COUNT_ONE;
          set_ovf = (count == COUNT_MAX);
        end
        if (external_trigger_enable && trig_fall)
          set_ext = 1'b1;
      end
      MODE_RELOAD:
      begin
        if (down_count_enable)
        begin
          // Trigger pin is the direction here, so it never reloads
          if (count_tick && trig_level)
          begin
            if (count == COUNT_MAX)
            begin
              next_count = reload_value;
              set_ovf = 1'b1;
              tog_ext = 1'b1;
            end
            else
              next_count = count + COUNT_ONE;
          end
          else if (count_tick)
          begin
            if (count == reload_value)
            begin
              next_count = COUNT_MAX;
              set_ovf = 1'b1;
              tog_ext = 1'b1;
            end
            else
              next_count = count - COUNT_ONE;
          end
        end
        else
        begin
          if (count_tick)
          begin
            if (count == COUNT_MAX)
            begin
              next_count = reload_value;
              set_ovf = 1'b1;
            end
            else
              next_count = count + COUNT_ONE;
          end
          if (external_trigger_enable && trig_fall)
          begin
            next_count = reload_value;
            set_ext = 1'b1;
          end
        end
      end
    endcase
    // Software byte writes win over counting
    if (cnt_lo_wr)
      next_count[DATA_W-1:0] = reg_wdata_in;
    if (cnt_hi_wr)
      next_count[COUNT_W-1:DATA_W] = reg_wdata_in;
  end

  // A hardware set wins over a software clear in the same cycle
  assign next_ovf = (ctl_wr ? reg_wdata_in[CTL_OVF] : overflow_flag) |
                    set_ovf;
  assign next_ext = tog_ext ? ~external_edge_flag :
                    ((ctl_wr ? reg_wdata_in[CTL_EXT] : external_edge_flag) |
                     set_ext);

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      overflow_flag <= CONTROL_RST[CTL_OVF];
      external_edge_flag <= CONTROL_RST[CTL_EXT];
    end
    else if (ce_in)
    begin
      overflow_flag <= next_ovf;
      external_edge_flag <= next_ext;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rx_baud_select <= CONTROL_RST[CTL_RX_BAUD];
      tx_baud_select <= CONTROL_RST[CTL_TX_BAUD];
      external_trigger_enable <= CONTROL_RST[CTL_EXT_EN];
      run_control <= CONTROL_RST[CTL_RUN];
      counter_select <= CONTROL_RST[CTL_COUNTER];
      capture_reload_select <= CONTROL_RST[CTL_CAPTURE];
    end
    else if (ce_in && ctl_wr)
    begin
      rx_baud_select <= reg_wdata_in[CTL_RX_BAUD];
      tx_baud_select <= reg_wdata_in[CTL_TX_BAUD];
      external_trigger_enable <= reg_wdata_in[CTL_EXT_EN];
      run_control <= reg_wdata_in[CTL_RUN];
      counter_select <= reg_wdata_in[CTL_COUNTER];
      capture_reload_select <= reg_wdata_in[CTL_CAPTURE];
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      clock_out_enable <= MODE_RST[MOD_CLK_OUT];
      down_count_enable <= MODE_RST[MOD_DOWN_EN];
    end
    else if (ce_in && mode_wr)
    begin
      clock_out_enable <= reg_wdata_in[MOD_CLK_OUT];
      down_count_enable <= reg_wdata_in[MOD_DOWN_EN];
    end
  end

  // Reload pair is not write-protected while running
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      reload_low_byte <= COUNT_RST[DATA_W-1:0];
      reload_high_byte <= COUNT_RST[COUNT_W-1:DATA_W];
    end
    else if (ce_in && reg_wr_in)
    begin
      if (reg_addr_in == REG_RELOAD_LO)
        reload_low_byte <= reg_wdata_in;
      if (reg_addr_in == REG_RELOAD_HI)
        reload_high_byte <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      count <= COUNT_RST;
    else if (ce_in)
      count <= next_count;
  end

  // Toggle per rollover gives the 50 percent duty clock
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      clock_out_level <= 1'b0;
    else if (ce_in && roll_clk)
      clock_out_level <= ~clock_out_level;
  end

  assign timer_clock_pin_out = clock_out_level;
  assign timer_clock_pin_oe_out = clock_out_enable;
  assign timer_irq_out = timer_irq_enable_in &
                         (overflow_flag | external_edge_flag);

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_baud_tick_out <= 1'b0;
      rx_baud_tick_out <= 1'b0;
    end
    else if (ce_in)
    begin
      tx_baud_tick_out <= tx_baud_select ? roll_baud :
                          other_timer_overflow_in;
      rx_baud_tick_out <= rx_baud_select ? roll_baud :
                          other_timer_overflow_in;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      reg_rdata_out <= READ_ZERO;
    else if (ce_in && reg_rd_in)
    begin
      unique case (reg_addr_in)
        REG_CONTROL:
          reg_rdata_out <= {overflow_flag, external_edge_flag,
                            rx_baud_select, tx_baud_select,
                            external_trigger_enable, run_control,
                            counter_select, capture_reload_select};
        REG_MODE:
          reg_rdata_out <= {6'h00, clock_out_enable, down_count_enable};
        REG_COUNT_LO: reg_rdata_out <= count[DATA_W-1:0];
        REG_COUNT_HI: reg_rdata_out <= count[COUNT_W-1:DATA_W];
        REG_RELOAD_LO: reg_rdata_out <= reload_low_byte;
        REG_RELOAD_HI: reg_rdata_out <= reload_high_byte;
        default: reg_rdata_out <= READ_ZERO;
      endcase
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  AST_DOWN_EN_ONLY_BY_WRITE: assert property (
    $rose(down_count_enable) |-> $past(ce_in && mode_wr))
    else $error("down count enable rose without a write");

  AST_UP_RELOAD: assert property (
    ce_in && count_tick && mode == MODE_RELOAD && !down_count_enable &&
    count == COUNT_MAX && !cnt_wr
    |=> count == $past(reload_value) && overflow_flag)
    else $error("up overflow did not reload and flag");

  AST_TRIG_RELOAD: assert property (
    ce_in && trig_fall && mode == MODE_RELOAD && !down_count_enable &&
    external_trigger_enable && !cnt_wr
    |=> count == $past(reload_value) && external_edge_flag)
    else $error("trigger fall did not reload and flag");

  AST_IRQ_ON_FLAG: assert property (
    ce_in && set_ovf && timer_irq_enable_in
    |=> timer_irq_out || !timer_irq_enable_in)
    else $error("overflow did not raise the interrupt");

  AST_EDGE_NEEDS_LOW: assert property (
    trig_fall |-> machine_tick && !trig_level)
    else $error("trigger fall seen without a low sample");

  AST_UPDOWN_UP: assert property (
    ce_in && count_tick && mode == MODE_RELOAD && down_count_enable &&
    trig_level && count == COUNT_MAX && !cnt_wr
    |=> count == $past(reload_value) && overflow_flag)
    else $error("up/down overflow did not reload");

  AST_UNDERFLOW: assert property (
    ce_in && count_tick && mode == MODE_RELOAD && down_count_enable &&
    !trig_level && count == reload_value && !cnt_wr
    |=> count == COUNT_MAX && overflow_flag)
    else $error("underflow did not load all ones");

  AST_EXT_TOGGLE: assert property (
    ce_in && tog_ext |=> external_edge_flag != $past(external_edge_flag))
    else $error("external flag did not toggle");

  AST_CLKOUT_QUIET: assert property (
    ce_in && roll_clk && !ctl_wr
    |=> clock_out_level != $past(clock_out_level) &&
        overflow_flag == $past(overflow_flag))
    else $error("clock-out rollover misbehaved");

  AST_BAUD_QUIET: assert property (
    ce_in && roll_baud && !ctl_wr && !cnt_wr
    |=> count == $past(reload_value) &&
        overflow_flag == $past(overflow_flag))
    else $error("baud rollover set flag or missed reload");

  AST_TX_ROUTE: assert property (
    ce_in && roll_baud && tx_baud_select |=> tx_baud_tick_out)
    else $error("baud pulse not routed to transmitter");

endmodule

// ==== tb/t2r_partner.sv ====
/*
  Far-side model: trigger pin, external count pin, other timer overflow.
  Assumes the timer's clock; the count pin is driven unless oe is high.
*/
`timescale 1ns/10ps
module t2r_partner
(
  input wire logic clk_sys_in,
  input wire logic trig_cmd_in,
  input wire logic burst_in,
  input wire logic pin_out_in,
  input wire logic pin_oe_in,
  output logic trig_out = 1'b1,
  output logic pin_wire_out,
  output logic other_ovf_out = 1'b0
);
  logic [3:0] hold = 4'h0;
  logic [7:0] burst_cnt = 8'h00;
  logic [2:0] oth = 3'h0;
  logic src = 1'b1;

  // Level may only change after a full machine cycle
  always @(posedge clk_sys_in)
  begin
    if (hold != 4'hC)
      hold <= hold + 4'h1;
    else if (trig_cmd_in != trig_out)
    begin
      trig_out <= trig_cmd_in;
      hold <= 4'h0;
    end
  end

  // Ten falls, period 16 clocks: above the twelve-clock minimum
  always @(posedge clk_sys_in)
  begin
    if (burst_in)
      burst_cnt <= 8'hA0;
    else if (burst_cnt != 8'h00)
      burst_cnt <= burst_cnt - 8'h01;
    src <= ~burst_cnt[3];
    oth <= (oth == 3'h6) ? 3'h0 : oth + 3'h1;
    other_ovf_out <= (oth == 3'h6);
  end

  assign pin_wire_out = pin_oe_in ? pin_out_in : src;
endmodule

// ==== tb/test_timer2_reload_clockout_baud.sv ====
/*
  Self-checking bench for the reload/clock-out/baud timer.
  Assumes 6-clock machine cycles unless a test selects 12.
*/
`timescale 1ns/10ps
module test_timer2_reload_clockout_baud
  import t2r_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk12 = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic irq_en = 1'b0;
  logic trig_cmd = 1'b1;
  logic burst = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata, rnd;
  logic pin_wire, pin_out, oe, trig, oth, irq, tx, rx;
  logic rd_pend = 1'b0;
  logic pin_q = 1'b0;
  logic [15:0] tx_cnt = '0, tx_last = '0, rx_cnt = '0, rx_last = '0;
  logic [15:0] pin_cnt = '0, pin_last = '0;
  // Longest baud period since the last clear; a stray reload stretches it
  logic [15:0] tx_max = '0;
  logic tx_max_clr = 1'b0;
  logic [DATA_W-1:0] exp_q[$];
  int n_fail = 0, comparisons = 0, cyc = 0;

  initial
  begin
    forever #4 clk = ~clk;
  end

  t2r_timer u_dut (.clk_sys_in(clk), .rst_in(rst), .ce_in(1'b1),
    .clk12_mode_in(clk12), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .timer_clock_pin_in(pin_wire), .timer_clock_pin_out(pin_out),
    .timer_clock_pin_oe_out(oe), .trigger_direction_input_in(trig),
    .other_timer_overflow_in(oth), .timer_irq_enable_in(irq_en),
    .timer_irq_out(irq), .tx_baud_tick_out(tx), .rx_baud_tick_out(rx));

  t2r_partner u_far (.clk_sys_in(clk), .trig_cmd_in(trig_cmd),
    .burst_in(burst), .pin_out_in(pin_out), .pin_oe_in(oe),
    .trig_out(trig), .pin_wire_out(pin_wire), .other_ovf_out(oth));

  task check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task close_out;
    $display("compares %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Gap cycle after each strobe keeps one assignment per time step
  task wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    exp_q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask

  task check_irq(input logic e);
    #1;
    check(16'(irq), 16'(e));
    idle(1);
  endtask

  always @(posedge clk)
  begin
    rd_pend <= rd;
    if (rd_pend)
      check({8'h00, rdata}, {8'h00, exp_q.pop_front()});
    pin_q <= pin_out;
    tx_cnt <= tx ? 16'h0001 : tx_cnt + 16'h0001;
    rx_cnt <= rx ? 16'h0001 : rx_cnt + 16'h0001;
    pin_cnt <= (pin_out && !pin_q) ? 16'h0001 : pin_cnt + 16'h0001;
    if (tx)
      tx_last <= tx_cnt;
    if (tx_max_clr)
      tx_max <= 16'h0000;
    else if (tx && tx_cnt > tx_max)
      tx_max <= tx_cnt;
    if (rx)
      rx_last <= rx_cnt;
    if (pin_out && !pin_q)
      pin_last <= pin_cnt;
    cyc <= cyc + 1;
    if (cyc == 10000)
    begin
      n_fail++;
      close_out;
    end
  end

  initial
  begin
    rnd = 8'($urandom(99723));
    idle(5);
    rst <= 1'b0;
    idle(1);
    rd_reg(REG_CONTROL, CONTROL_RST);
    rd_reg(REG_MODE, 8'h00);
    rd_reg(3'h6, READ_ZERO);
    wr_reg(REG_RELOAD_HI, rnd);
    wr_reg(REG_RELOAD_LO, ~rnd);
    rd_reg(REG_RELOAD_HI, rnd);
    rd_reg(REG_RELOAD_LO, ~rnd);
    $display("test registers done");
    irq_en <= 1'b1;
    wr_reg(REG_RELOAD_HI, 8'hFF);
    wr_reg(REG_RELOAD_LO, 8'hFF);
    wr_reg(REG_COUNT_HI, 8'hFF);
    wr_reg(REG_COUNT_LO, 8'hFC);
    wr_reg(REG_CONTROL, 8'h04);
    idle(40);
    rd_reg(REG_CONTROL, 8'h84);
    check_irq(1'b1);
    irq_en <= 1'b0;
    idle(1);
    check_irq(1'b0);
    irq_en <= 1'b1;
    wr_reg(REG_CONTROL, 8'h00);
    rd_reg(REG_COUNT_LO, 8'hFF);
    rd_reg(REG_COUNT_HI, 8'hFF);
    $display("test reload done");
    wr_reg(REG_RELOAD_HI, 8'h12);
    wr_reg(REG_RELOAD_LO, 8'h34);
    wr_reg(REG_COUNT_HI, 8'h56);
    wr_reg(REG_CONTROL, 8'h0C);
    idle(20);
    trig_cmd <= 1'b0;
    idle(60);
    rd_reg(REG_CONTROL, 8'h4C);
    rd_reg(REG_COUNT_HI, 8'h12);
    check_irq(1'b1);
    trig_cmd <= 1'b1;
    wr_reg(REG_CONTROL, 8'h00);
    $display("test trigger reload done");
    wr_reg(REG_MODE, 8'h01);
    trig_cmd <= 1'b0;
    wr_reg(REG_RELOAD_HI, 8'h10);
    wr_reg(REG_RELOAD_LO, 8'h00);
    wr_reg(REG_COUNT_HI, 8'h10);
    wr_reg(REG_COUNT_LO, 8'h03);
    idle(30);
    wr_reg(REG_CONTROL, 8'h04);
    idle(60);
    rd_reg(REG_CONTROL, 8'hC4);
    rd_reg(REG_COUNT_HI, 8'hFF);
    wr_reg(REG_CONTROL, 8'h00);
    trig_cmd <= 1'b1;
    wr_reg(REG_COUNT_LO, 8'hFE);
    wr_reg(REG_COUNT_HI, 8'hFF);
    idle(30);
    wr_reg(REG_CONTROL, 8'h04);
    idle(40);
    rd_reg(REG_CONTROL, 8'hC4);
    rd_reg(REG_COUNT_HI, 8'h10);
    wr_reg(REG_CONTROL, 8'h00);
    wr_reg(REG_MODE, 8'h00);
    $display("test up down done");
    wr_reg(REG_RELOAD_HI, 8'hFF);
    wr_reg(REG_RELOAD_LO, 8'hF0);
    // Start near the top so rollovers come within the test window
    wr_reg(REG_COUNT_HI, 8'hFF);
    wr_reg(REG_COUNT_LO, 8'hF0);
    wr_reg(REG_CONTROL, 8'h1D);
    idle(80);
    check(tx_last, 16'd16);
    check(rx_last, 16'd7);
    tx_max_clr <= 1'b1;
    idle(1);
    tx_max_clr <= 1'b0;
    trig_cmd <= 1'b0;
    idle(60);
    rd_reg(REG_CONTROL, 8'h5D);
    check(tx_max, 16'd16);
    trig_cmd <= 1'b1;
    wr_reg(REG_CONTROL, 8'h3D);
    idle(80);
    check(rx_last, 16'd16);
    check_irq(1'b0);
    wr_reg(REG_CONTROL, 8'h00);
    clk12 <= 1'b1;
    wr_reg(REG_CONTROL, 8'h3D);
    idle(150);
    check(tx_last, 16'd32);
    wr_reg(REG_CONTROL, 8'h00);
    clk12 <= 1'b0;
    $display("test baud done");
    wr_reg(REG_MODE, 8'h02);
    wr_reg(REG_RELOAD_LO, 8'hFC);
    wr_reg(REG_CONTROL, 8'h04);
    idle(60);
    check(pin_last, 16'd8);
    check(16'(oe), 16'h0001);
    rd_reg(REG_CONTROL, 8'h04);
    wr_reg(REG_CONTROL, 8'h00);
    clk12 <= 1'b1;
    wr_reg(REG_CONTROL, 8'h04);
    idle(100);
    check(pin_last, 16'd16);
    wr_reg(REG_CONTROL, 8'h00);
    clk12 <= 1'b0;
    wr_reg(REG_MODE, 8'h00);
    $display("test clock out done");
    // No baud select: capture select holds, so FFFF wraps to zero
    wr_reg(REG_COUNT_LO, 8'hFE);
    wr_reg(REG_COUNT_HI, 8'hFF);
    wr_reg(REG_CONTROL, 8'h05);
    idle(30);
    rd_reg(REG_CONTROL, 8'h85);
    rd_reg(REG_COUNT_HI, 8'h00);
    check_irq(1'b1);
    wr_reg(REG_CONTROL, 8'h00);
    $display("test capture select done");
    wr_reg(REG_COUNT_LO, 8'h00);
    wr_reg(REG_COUNT_HI, 8'h00);
    wr_reg(REG_CONTROL, 8'h06);
    burst <= 1'b1;
    idle(1);
    burst <= 1'b0;
    idle(200);
    rd_reg(REG_COUNT_LO, 8'h0A);
    rd_reg(REG_COUNT_HI, 8'h00);
    wr_reg(REG_CONTROL, 8'h00);
    $display("test counter done");
    // Reset with the timer stopped must drop down-count enable again
    wr_reg(REG_MODE, 8'h01);
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    idle(1);
    rd_reg(REG_MODE, 8'h00);
    $display("test reset done");
    idle(2);
    close_out;
  end
endmodule
